//--- core/dmi_defines.vh
// Notes on behaviour
// RULE1: Indirect port accesses go to the location held in that port's pointer.
// RULE2: First indirect port with its one-byte pointer reaches sector 0 only.
// RULE3: Ports a and b use low pointer plus sector pointer, reaching every sector.
// RULE4: Indirect ports store nothing; reading gives 00H, writing does nothing.
// RULE5: Five pointer bytes are real storage, readable and writable like registers.
// RULE6: Extended direct addresses reach any location in every sector.
// RULE7: Extended address holds sector above low byte; 1F0H is F0H of sector 1.
// RULE8: Arithmetic results are placed in the accumulator.
// RULE9: No move between two registers; transfers pass through the accumulator.
// RULE10: Writing the program counter low byte jumps to that program location.
// RULE11: Only the low byte is replaced, so the jump stays in the page.
// RULE12: A program counter low byte write inserts one dummy cycle.
// RULE13: Table pointers give table address; software loads and steps them.
// RULE14: Table read puts the fetched word's high byte in the latch register.
// RULE15: Table read writes the fetched low byte to the operand location.
// RULE16: Unimplemented special addresses read as 00H.
`ifndef DMI_DEFINES_VH
`define DMI_DEFINES_VH

// Special register offsets in sector 0
`define DMI_IAR_SECTOR0   8'h00
`define DMI_MP_SECTOR0    8'h01
`define DMI_IAR_A         8'h02
`define DMI_MP_A_LOW      8'h03
`define DMI_MP_A_SECTOR   8'h04
`define DMI_ACC           8'h05
`define DMI_PC_LOW        8'h06
`define DMI_TBL_LOW       8'h07
`define DMI_TBL_LATCH     8'h08
`define DMI_TBL_HIGH      8'h09
`define DMI_IAR_B         8'h0c
`define DMI_MP_B_LOW      8'h0d
`define DMI_MP_B_SECTOR   8'h0e
`define DMI_SFR_TOP       8'h80
`define DMI_RST_BYTE      8'h00

// Bus map: data memory at 4 x extended address, control words above
`define DMI_CMD_OFS       16'h8000
`define DMI_PCSTAT_OFS    16'h8004

// Command word fields and operations
`define DMI_CMD_OP_MSB    13
`define DMI_CMD_OP_LSB    12
`define DMI_OP_LOAD       2'h0
`define DMI_OP_STORE      2'h1
`define DMI_OP_ADD        2'h2
`define DMI_OP_TABRD      2'h3

`endif

//--- core/dmi_resolve.v
`timescale 1ns/10ps
`include "dmi_defines.vh"

module dmi_resolve #(
  parameter SECT_W = 1
) (
  // Address in
  input  wire [SECT_W+7:0] ea_in,
  // Pointer bytes
  input  wire [7:0]        mp0,
  input  wire [7:0]        mp_a_low,
  input  wire [7:0]        mp_a_sector,
  input  wire [7:0]        mp_b_low,
  input  wire [7:0]        mp_b_sector,
  // Effective address
  output reg  [SECT_W+7:0] ea_out
);

  wire in_sec0;

  assign in_sec0 = (ea_in[SECT_W+7:8] == {SECT_W{1'b0}});

  always @*
  begin
    ea_out = ea_in;
    if (in_sec0)
    begin
      // RULE1: port redirected
      if (ea_in[7:0] == `DMI_IAR_SECTOR0)
      begin
        // RULE2: sector 0 only
        ea_out = {{SECT_W{1'b0}}, mp0};
      end
      else if (ea_in[7:0] == `DMI_IAR_A)
      begin
        // RULE3: sector from pointer
        ea_out = {mp_a_sector[SECT_W-1:0], mp_a_low};
      end
      else if (ea_in[7:0] == `DMI_IAR_B)
      begin
        // RULE3: sector from pointer
        ea_out = {mp_b_sector[SECT_W-1:0], mp_b_low};
      end
    end
  end

endmodule

//--- core/dmi_data_mem_addr.v
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "dmi_defines.vh"

module dmi_data_mem_addr #(
  parameter SECT_W = 1,
  parameter PC_W   = 13
) (
  // Clock, reset, enable
  input  wire              SYS_CLK,
  input  wire              RESETN,
  input  wire              CLK_EN,
  // AHB-Lite slave
  input  wire              HSEL,
  input  wire [31:0]       HADDR,
  input  wire [1:0]        HTRANS,
  input  wire              HWRITE,
  input  wire [2:0]        HSIZE,
  input  wire [31:0]       HWDATA,
  input  wire              HREADY,
  output wire [31:0]       HRDATA,
  output wire              HREADYOUT,
  output wire              HRESP,
  // Program memory
  output wire [15:0]       PROG_ADDR,
  input  wire [15:0]       PROG_DATA,
  // Program counter
  input  wire              PC_ADVANCE,
  output wire [PC_W-1:0]   PC,
  output wire              DUMMY_CYCLE
);

  localparam EA_W    = SECT_W + 8;
  localparam RAM_N   = (1 << SECT_W) * 128;
  localparam ST_IDLE = 4'b0001;
  localparam ST_WR   = 4'b0010;
  localparam ST_RD   = 4'b0100;
  localparam ST_RDY  = 4'b1000;

  reg  [3:0]        state_q;
  reg  [3:0]        state_d;
  reg  [15:0]       ph_addr_q;
  reg  [31:0]       hrdata_q;
  reg  [7:0]        mp0_q;
  reg  [7:0]        mp0_d;
  reg  [7:0]        mpa_low_q;
  reg  [7:0]        mpa_low_d;
  reg  [7:0]        mpa_sec_q;
  reg  [7:0]        mpa_sec_d;
  reg  [7:0]        mpb_low_q;
  reg  [7:0]        mpb_low_d;
  reg  [7:0]        mpb_sec_q;
  reg  [7:0]        mpb_sec_d;
  reg  [7:0]        acc_q;
  reg  [7:0]        acc_d;
  reg  [7:0]        tbl_low_q;
  reg  [7:0]        tbl_low_d;
  reg  [7:0]        tbl_high_q;
  reg  [7:0]        tbl_high_d;
  reg  [7:0]        tbl_latch_q;
  reg  [7:0]        tbl_latch_d;
  reg  [PC_W-1:0]   pc_q;
  reg  [PC_W-1:0]   pc_d;
  reg               dummy_q;
  reg               dummy_d;
  reg  [7:0]        mem [0:RAM_N-1];
  reg  [7:0]        rd_val;
  reg  [31:0]       rd_word;

  wire              addr_take;
  wire              dmem_hit;
  wire              cmd_hit;
  wire              pcs_hit;
  wire [EA_W-1:0]   bus_ea;
  wire [EA_W-1:0]   res_in;
  wire [EA_W-1:0]   res;
  wire [SECT_W-1:0] res_sec;
  wire [7:0]        res_off;
  wire              in_sfr;
  wire              in_ram;
  wire [EA_W-2:0]   ram_idx;
  wire [1:0]        op;
  wire              bus_wr;
  wire              cmd_go;
  wire              wr_en;
  wire [7:0]        wr_data;
  wire              ram_we;
  wire              sfr_we;

  // Bus phase tracking
  assign addr_take = HSEL && HTRANS[1] && HREADY;
  assign HREADYOUT = CLK_EN && !state_q[2];
  assign HRESP     = 1'b0;
  assign HRDATA    = hrdata_q;

  // RULE6: whole space on the bus
  assign dmem_hit = ((ph_addr_q >> (EA_W + 2)) == 16'h0000);
  assign cmd_hit  = (ph_addr_q == `DMI_CMD_OFS);
  assign pcs_hit  = (ph_addr_q == `DMI_PCSTAT_OFS);
  assign bus_ea   = ph_addr_q[EA_W+1:2];

  assign op     = HWDATA[`DMI_CMD_OP_MSB:`DMI_CMD_OP_LSB];
  assign bus_wr = CLK_EN && (state_q == ST_WR) && dmem_hit;
  assign cmd_go = CLK_EN && (state_q == ST_WR) && cmd_hit;
  assign res_in = cmd_hit ? HWDATA[EA_W-1:0] : bus_ea;

  dmi_resolve #(
    .SECT_W      (SECT_W)
  ) u_resolve (
    .ea_in       (res_in),
    .mp0         (mp0_q),
    .mp_a_low    (mpa_low_q),
    .mp_a_sector (mpa_sec_q),
    .mp_b_low    (mpb_low_q),
    .mp_b_sector (mpb_sec_q),
    .ea_out      (res)
  );

  // RULE7: sector above low byte
  assign res_sec = res[EA_W-1:8];
  assign res_off = res[7:0];
  assign in_sfr  = (res_sec == {SECT_W{1'b0}}) && (res_off < `DMI_SFR_TOP);
  assign in_ram  = (res_off >= `DMI_SFR_TOP);
  assign ram_idx = {res_sec, res_off[6:0]};

  // RULE9: only accumulator as transfer source
  assign wr_en   = bus_wr || (cmd_go && ((op == `DMI_OP_STORE) || (op == `DMI_OP_TABRD)));
  // RULE15: low byte to operand
  assign wr_data = bus_wr ? HWDATA[7:0] :
                   ((op == `DMI_OP_TABRD) ? PROG_DATA[7:0] : acc_q);
  assign ram_we  = wr_en && in_ram;
  assign sfr_we  = wr_en && in_sfr;

  // RULE13: table address from pointers
  assign PROG_ADDR   = {tbl_high_q, tbl_low_q};
  assign PC          = pc_q;
  assign DUMMY_CYCLE = dummy_q;

  // Read of resolved location
  always @*
  begin
    rd_val = 8'h00;
    if (in_ram)
    begin
      rd_val = mem[ram_idx];
    end
    else if (in_sfr)
    begin
      // RULE4: ports read as zero
      // RULE16: unused reads as zero
      case (res_off)
        `DMI_MP_SECTOR0:  rd_val = mp0_q;
        `DMI_MP_A_LOW:    rd_val = mpa_low_q;
        `DMI_MP_A_SECTOR: rd_val = mpa_sec_q;
        `DMI_MP_B_LOW:    rd_val = mpb_low_q;
        `DMI_MP_B_SECTOR: rd_val = mpb_sec_q;
        `DMI_ACC:         rd_val = acc_q;
        `DMI_PC_LOW:      rd_val = pc_q[7:0];
        `DMI_TBL_LOW:     rd_val = tbl_low_q;
        `DMI_TBL_LATCH:   rd_val = tbl_latch_q;
        `DMI_TBL_HIGH:    rd_val = tbl_high_q;
        default:          rd_val = 8'h00;
      endcase
    end
  end

  // Bus read word
  always @*
  begin
    rd_word = 32'h00000000;
    if (dmem_hit)
    begin
      rd_word = {24'h000000, rd_val};
    end
    else if (cmd_hit)
    begin
      rd_word = {24'h000000, acc_q};
    end
    else if (pcs_hit)
    begin
      rd_word = {{(32 - PC_W){1'b0}}, pc_q};
    end
  end

  always @*
  begin
    state_d = ST_IDLE;
    case (state_q)
      ST_RD:
        state_d = ST_RDY;
      default:
        if (addr_take)
        begin
          state_d = HWRITE ? ST_WR : ST_RD;
        end
    endcase
  end

  // Register next values
  always @*
  begin
    mp0_d       = mp0_q;
    mpa_low_d   = mpa_low_q;
    mpa_sec_d   = mpa_sec_q;
    mpb_low_d   = mpb_low_q;
    mpb_sec_d   = mpb_sec_q;
    acc_d       = acc_q;
    tbl_low_d   = tbl_low_q;
    tbl_high_d  = tbl_high_q;
    tbl_latch_d = tbl_latch_q;
    dummy_d     = 1'b0;
    // RULE12: no advance in dummy cycle
    pc_d        = (PC_ADVANCE && !dummy_q) ? pc_q + {{(PC_W-1){1'b0}}, 1'b1} : pc_q;
    if (sfr_we)
    begin
      // RULE5: pointers are storage
      case (res_off)
        `DMI_MP_SECTOR0:  mp0_d = wr_data;
        `DMI_MP_A_LOW:    mpa_low_d = wr_data;
        `DMI_MP_A_SECTOR: mpa_sec_d = wr_data;
        `DMI_MP_B_LOW:    mpb_low_d = wr_data;
        `DMI_MP_B_SECTOR: mpb_sec_d = wr_data;
        `DMI_ACC:         acc_d = wr_data;
        `DMI_TBL_LOW:     tbl_low_d = wr_data;
        `DMI_TBL_HIGH:    tbl_high_d = wr_data;
        `DMI_PC_LOW:
        begin
          // RULE10: jump on write
          // RULE11: page kept
          pc_d    = {pc_q[PC_W-1:8], wr_data};
          // RULE12: one dummy cycle
          dummy_d = 1'b1;
        end
        default:
        begin
          dummy_d = 1'b0;
        end
      endcase
    end
    if (cmd_go)
    begin
      case (op)
        `DMI_OP_LOAD:
          acc_d = rd_val;
        // RULE8: result into accumulator
        `DMI_OP_ADD:
          acc_d = acc_q + rd_val;
        // RULE14: high byte latched
        `DMI_OP_TABRD:
          tbl_latch_d = PROG_DATA[15:8];
        default:
          acc_d = acc_q;
      endcase
    end
  end

  always @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_q     <= ST_IDLE;
      ph_addr_q   <= 16'h0000;
      hrdata_q    <= 32'h00000000;
      mp0_q       <= `DMI_RST_BYTE;
      mpa_low_q   <= `DMI_RST_BYTE;
      mpa_sec_q   <= `DMI_RST_BYTE;
      mpb_low_q   <= `DMI_RST_BYTE;
      mpb_sec_q   <= `DMI_RST_BYTE;
      acc_q       <= `DMI_RST_BYTE;
      tbl_low_q   <= `DMI_RST_BYTE;
      tbl_high_q  <= `DMI_RST_BYTE;
      tbl_latch_q <= `DMI_RST_BYTE;
      pc_q        <= {PC_W{1'b0}};
      dummy_q     <= 1'b0;
    end
    else if (CLK_EN)
    begin
      state_q     <= state_d;
      if (state_q != ST_RD && addr_take)
      begin
        ph_addr_q <= HADDR[15:0];
      end
      if (state_q == ST_RD)
      begin
        hrdata_q  <= rd_word;
      end
      mp0_q       <= mp0_d;
      mpa_low_q   <= mpa_low_d;
      mpa_sec_q   <= mpa_sec_d;
      mpb_low_q   <= mpb_low_d;
      mpb_sec_q   <= mpb_sec_d;
      acc_q       <= acc_d;
      tbl_low_q   <= tbl_low_d;
      tbl_high_q  <= tbl_high_d;
      tbl_latch_q <= tbl_latch_d;
      pc_q        <= pc_d;
      dummy_q     <= dummy_d;
    end
  end

  // General purpose RAM, no reset
  always @(posedge SYS_CLK)
  begin
    if (CLK_EN && ram_we)
    begin
      mem[ram_idx] <= wr_data;
    end
  end

endmodule

//--- sim/dmi_data_mem_addr_properties.sv
`timescale 1ns/10ps
module dmi_data_mem_addr_properties #(
  parameter PC_W = 13
) (
  // Clock and reset
  input wire            SYS_CLK,
  input wire            RESETN,
  input wire            CLK_EN,
  // Bus
  input wire            HSEL,
  input wire [31:0]     HADDR,
  input wire [1:0]      HTRANS,
  input wire            HWRITE,
  input wire [31:0]     HWDATA,
  input wire            HREADY,
  input wire [31:0]     HRDATA,
  input wire            HREADYOUT,
  input wire            HRESP,
  // Program side
  input wire [15:0]     PROG_ADDR,
  input wire            PC_ADVANCE,
  input wire [PC_W-1:0] PC,
  input wire            DUMMY_CYCLE
);
  reg  pcl_q;
  wire take = HSEL & HTRANS[1] & HREADY & CLK_EN;
  // Data phase of a low byte program counter write
  always @(posedge SYS_CLK or negedge RESETN)
    if (!RESETN)
      pcl_q <= 1'b0;
    else if (HREADY && CLK_EN)
      pcl_q <= take & HWRITE & (HADDR[15:0] == 16'h0018);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  a_resp_okay: assert property (HRESP == 1'b0)
    else $error("error response seen");
  a_read_wait: assert property (take && !HWRITE |=> !HREADYOUT)
    else $error("read without wait state");
  a_read_done: assert property (take && !HWRITE ##1 CLK_EN |=> HREADYOUT || !CLK_EN)
    else $error("read answer late");
  a_write_nowait: assert property (take && HWRITE |=> HREADYOUT || !CLK_EN)
    else $error("write stalled");
  a_stall_off: assert property (!CLK_EN |-> !HREADYOUT)
    else $error("ready while disabled");
  a_pcl_jump: assert property (pcl_q && CLK_EN |=> DUMMY_CYCLE && PC[7:0] == $past(HWDATA[7:0]))
    else $error("low byte write not taken");
  a_dummy_cause: assert property ($rose(DUMMY_CYCLE) |-> $past(pcl_q))
    else $error("spurious dummy cycle");
  a_pc_step: assert property (CLK_EN && PC_ADVANCE && !DUMMY_CYCLE && !pcl_q |=> PC == $past(PC) + 1'b1)
    else $error("counter did not step");
  a_pc_hold: assert property (CLK_EN && !pcl_q && (!PC_ADVANCE || DUMMY_CYCLE) |=> $stable(PC))
    else $error("counter moved");
  a_pc_freeze: assert property (!CLK_EN |=> $stable(PC) && $stable(PROG_ADDR))
    else $error("state moved while disabled");
  a_rdata_narrow: assert property (HRDATA[31:PC_W] == 0)
    else $error("upper read bits set");
endmodule

bind dmi_data_mem_addr dmi_data_mem_addr_properties #(.PC_W(PC_W)) dmi_data_mem_addr_properties_i (
  .SYS_CLK(SYS_CLK), .RESETN(RESETN), .CLK_EN(CLK_EN), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PROG_ADDR(PROG_ADDR), .PC_ADVANCE(PC_ADVANCE),
  .PC(PC), .DUMMY_CYCLE(DUMMY_CYCLE));

//--- sim/dmi_data_mem_addr_tb.sv
`timescale 1ns/10ps
module dmi_data_mem_addr_tb;
  reg         SYS_CLK, RESETN, CLK_EN, HSEL, HWRITE, PC_ADVANCE;
  reg  [31:0] HADDR, HWDATA, rv;
  reg  [1:0]  HTRANS;
  wire [31:0] HRDATA;
  wire        HREADYOUT, HRESP, DUMMY_CYCLE;
  wire [15:0] PROG_ADDR, PROG_DATA;
  wire [12:0] PC;
  integer     num_errors, n_compared, i;
  // Pointer offsets, one byte each, lowest first
  reg  [39:0] ptrs = 40'h0e0d040301;
  // Program word derived from its address
  assign PROG_DATA = {PROG_ADDR[7:0] ^ 8'ha5, PROG_ADDR[15:8]};
  dmi_data_mem_addr dmi_data_mem_addr_i (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .CLK_EN(CLK_EN), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PROG_ADDR(PROG_ADDR),
    .PROG_DATA(PROG_DATA), .PC_ADVANCE(PC_ADVANCE), .PC(PC), .DUMMY_CYCLE(DUMMY_CYCLE));
  initial
  begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  task conclude;
  begin
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
  begin
    n_compared++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      num_errors++;
    end
  end
  endtask
  task wait_rdy;
    integer n;
  begin
    n = 0;
    @(posedge SYS_CLK);
    while (HREADYOUT !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        num_errors++;
        conclude;
      end
      @(posedge SYS_CLK);
    end
  end
  endtask
  // Extended address in, word address on the bus
  task xfer(input w, input [31:0] a, input [31:0] d);
  begin
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a << 2;
    HWRITE <= w;
    wait_rdy;
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy;
    rv = HRDATA;
  end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input string nm, input [31:0] a, input [31:0] exp);
  begin
    xfer(1'b0, a, 32'h0);
    chk(nm, rv, exp);
  end
  endtask
  initial
  begin
    {HSEL, HWRITE, PC_ADVANCE, HTRANS, HADDR, HWDATA} = 0;
    CLK_EN = 1'b1;
    RESETN = 1'b0;
    num_errors = 0;
    n_compared = 0;
    repeat (5) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    @(posedge SYS_CLK);
    for (i = 0; i < 5; i++)
    begin
      rd("pointer reset", ptrs[i*8 +: 8], 0);
      wr(ptrs[i*8 +: 8], 8'h80 + i);
      rd("pointer", ptrs[i*8 +: 8], 8'h80 + i);
    end
    $display("pointers done");
    wr(9'h080, 8'h11);
    wr(9'h1f0, 8'h22);
    wr(9'h0f0, 8'h44);
    rd("ext s0", 9'h080, 8'h11);
    rd("ext s1", 9'h1f0, 8'h22);
    rd("port s0", 0, 8'h11);
    wr(0, 8'h55);
    rd("via s0", 9'h080, 8'h55);
    wr(1, 8'hf0);
    rd("s0 only", 0, 8'h44);
    wr(3, 8'hf0);
    wr(4, 8'h01);
    rd("port a", 2, 8'h22);
    wr(8'h0d, 8'hf0);
    wr(8'h0e, 8'h00);
    rd("port b s0", 8'h0c, 8'h44);
    wr(8'h0e, 8'h01);
    rd("port b s1", 8'h0c, 8'h22);
    wr(1, 8'h00);
    wr(0, 8'h77);
    rd("port self", 0, 0);
    rd("pointer kept", 1, 0);
    rd("unused", 8'h0b, 0);
    rd("s1 low", 9'h110, 0);
    $display("addressing done");
    wr(32'h2000, 32'h0080);
    wr(32'h2000, 32'h21f0);
    rd("acc sum", 5, 8'h77);
    wr(32'h2000, 32'h1081);
    rd("acc store", 9'h081, 8'h77);
    $display("accumulator done");
    wr(7, 8'h34);
    wr(9, 8'h12);
    // Pointer lands at the edge that ends the write
    @(posedge SYS_CLK);
    chk("prog addr", {16'h0, PROG_ADDR}, 32'h1234);
    wr(32'h2000, 32'h31f1);
    rd("table low", 9'h1f1, 8'h12);
    rd("table latch", 8, 8'h91);
    wr(8, 8'hff);
    rd("latch ro", 8, 8'h91);
    wr(7, 8'h35);
    @(posedge SYS_CLK);
    chk("prog step", {16'h0, PROG_ADDR}, 32'h1235);
    $display("table done");
    PC_ADVANCE <= 1'b1;
    repeat (300) @(posedge SYS_CLK);
    PC_ADVANCE <= 1'b0;
    wr(6, 8'h5a);
    rd("pc jump", 32'h2001, 32'h015a);
    rd("pc low", 6, 8'h5a);
    PC_ADVANCE <= 1'b1;
    wr(6, 8'h10);
    CLK_EN <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    CLK_EN <= 1'b1;
    // Dummy cycle swallows one advance, the next one counts
    repeat (2) @(posedge SYS_CLK);
    PC_ADVANCE <= 1'b0;
    rd("pc dummy", 32'h2001, 32'h0111);
    $display("program counter done");
    conclude;
  end
endmodule
